// ---- lpcf_pkg.sv ----
// Shared constants and carrier types for the low-power clock and freeze control block.
package lpcf_pkg;
  // ---------------------------------------------------------------------------
  // Clock control register
  // ---------------------------------------------------------------------------
  // The register answers only to supervisor data space accesses.
  localparam logic [2:0] COCR_FC = 3'h5;
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;
  localparam int TX_FLOAT_BIT = 13;
  localparam int RX_FLOAT_BIT = 12;
  localparam int BAUD_DIS_BIT = 11;
  localparam logic [10:0] COCR_RESERVED_ZERO = 11'h000;
  localparam logic [15:0] COCR_RESET = 16'h0000;
  // Drive mode encodings of the clock output.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_TWO_THIRDS = 2'h1;
  localparam logic [1:0] MODE_ONE_THIRD = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;

  // ---------------------------------------------------------------------------
  // Divider and recovery timing
  // ---------------------------------------------------------------------------
  localparam logic [10:0] BASE_DIV = 11'h002;
  localparam logic [10:0] PRESCALED_DIV = 11'h020;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;
  localparam logic [3:0] HOLD_LAST = 4'hF;
  localparam logic [4:0] DIVIDER_RESET = 5'h00;

  // Low-power and freeze bits of the system control word.
  typedef struct packed {
    logic [4:0] core_divider_select;
    logic sleep_enable;
    logic divider_prescale_sixteen;
    logic recovery_reset_select;
    logic halt_watchdog_enable;
    logic halt_timer_two_enable;
    logic halt_timer_one_enable;
  } lpcf_scw_type;

  // Implemented bits 15 to 11 of the clock control register.
  typedef struct packed {
    logic [1:0] clock_out_drive_mode;
    logic tx_clock_pin_float;
    logic rx_clock_pin_float;
    logic baud_pin_disable;
  } lpcf_cocr_type;
endpackage

// ---- lpcf_div.sv ----
// Core clock divider that emits one tick per divided core clock period.
`timescale 1ns/1ns
module lpcf_div (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run_full,
  input wire logic [4:0] divider_select,
  input wire logic prescale_sixteen,
  output logic core_clk_tick
);
  typedef struct packed {
    logic [3:0] pre_cnt;
    logic [4:0] div_cnt;
    logic half;
    logic tick;
  } lpcf_div_state_type;

  lpcf_div_state_type q;
  lpcf_div_state_type d;

  // ---------------------------------------------------------------------------
  // Prescaler, programmable stage and final halving
  // ---------------------------------------------------------------------------
  // The chain is held cleared at full speed so every sleep starts from a known phase.
  always_comb begin
    logic pre_en;
    logic div_en;
    pre_en = 1'b0;
    div_en = 1'b0;
    d = q;
    if (run_full) begin
      d = '0;
      d.tick = 1'b1;
    end else begin
      pre_en = !prescale_sixteen || (q.pre_cnt == lpcf_pkg::PRESCALE_LAST);
      d.pre_cnt = prescale_sixteen ? q.pre_cnt + 4'h1 : 4'h0;
      div_en = pre_en && (q.div_cnt == divider_select);
      if (pre_en) begin
        d.div_cnt = div_en ? lpcf_pkg::DIVIDER_RESET : q.div_cnt + 5'h01;
      end
      if (div_en) begin
        d.half = !q.half;
      end
      d.tick = div_en && q.half;
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign core_clk_tick = q.tick;
endmodule

// ---- lpcf_system_clock_output.sv ----
// Clock output pin generator with a glitch-free drive mode change.
`timescale 1ns/1ns
module lpcf_system_clock_output (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] mode_request,
  output logic system_clock_output,
  output logic system_clock_output_oe_b,
  output logic [1:0] clock_out_drive_mode
);
  typedef struct packed {
    logic phase;
    logic [1:0] mode;
    logic pin;
    logic oe_b;
  } lpcf_system_clock_output_state_type;

  lpcf_system_clock_output_state_type q;
  lpcf_system_clock_output_state_type d;

  // ---------------------------------------------------------------------------
  // Mode update
  // ---------------------------------------------------------------------------
  // A new mode is taken only at an edge that ends a high phase, so the pin never spikes.
  always_comb begin
    d = q;
    d.phase = !q.phase;
    if (q.phase) begin
      d.mode = mode_request;
    end
    // The disabled output is not driven; the pullup holds the wire high.
    d.pin = (d.mode == lpcf_pkg::MODE_OFF) ? 1'b1 : d.phase;
    d.oe_b = (d.mode == lpcf_pkg::MODE_OFF);
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign system_clock_output = q.pin;
  assign system_clock_output_oe_b = q.oe_b;
  assign clock_out_drive_mode = q.mode;
endmodule

// ---- lpcf_ctrl.sv ----
// Top of the low-power clock, clock control register and freeze control block.
`timescale 1ns/1ns
module lpcf_ctrl (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cocr_sel,
  input wire logic cocr_write,
  input wire logic [2:0] cocr_fc,
  input wire logic [15:0] cocr_wdata,
  output logic [15:0] cocr_rdata,
  output logic cocr_ack,
  input wire lpcf_pkg::lpcf_scw_type system_control_word,
  input wire logic stop_executed,
  input wire logic [15:0] interrupt_pending_word,
  input wire logic [15:0] interrupt_mask_word,
  input wire logic debug_halt_input,
  input wire logic dma_cycle_active,
  input wire logic dma_ack,
  input wire logic scc_tx_clock_out,
  input wire logic scc_tx_clock_drive,
  input wire logic scc_rx_clock_out,
  input wire logic scc_rx_clock_drive,
  input wire logic baud_generator_out,
  output logic core_clk_tick,
  output logic core_reset,
  output logic sleeping,
  output logic comms_freeze,
  output logic dma_hold,
  output logic dma_bus_release,
  output logic [2:0] timer_halt,
  output logic serial_tx_clock_pin,
  output logic serial_tx_clock_pin_oe_b,
  output logic serial_rx_clock_pin,
  output logic serial_rx_clock_pin_oe_b,
  output logic baud_generator_pin,
  output logic system_clock_output,
  output logic system_clock_output_oe_b,
  output logic [1:0] clock_out_drive_mode
);
  typedef enum logic [1:0] {LPCF_RUN, LPCF_SLEEP, LPCF_CORE_RESET} lpcf_lp_state_type;

  typedef struct packed {
    lpcf_lp_state_type lp;
    logic [3:0] hold_cnt;
    lpcf_pkg::lpcf_scw_type scw;
    lpcf_pkg::lpcf_cocr_type cocr;
    logic [15:0] rdata;
    logic ack;
    logic sleeping;
    logic core_reset;
    logic comms_freeze;
    logic dma_hold;
    logic dma_release;
    logic [2:0] timer_halt;
    logic tx_o;
    logic tx_oe_b;
    logic rx_o;
    logic rx_oe_b;
    logic baud_o;
  } lpcf_main_state_type;

  lpcf_main_state_type q;
  lpcf_main_state_type d;
  logic wake;
  logic access_ok;
  logic [2:0] halt_en;

  // Any pending source that software left unmasked wakes the core.
  function automatic logic lpcf_wake(input logic [15:0] pend, input logic [15:0] mask);
    lpcf_wake = |(pend & mask);
  endfunction

  // Core clock ratio in sleep for a given prescale and divider setting.
  function automatic logic [10:0] lpcf_ratio(input logic pre, input logic [4:0] sel);
    logic [10:0] base;
    base = pre ? lpcf_pkg::PRESCALED_DIV : lpcf_pkg::BASE_DIV;
    lpcf_ratio = base * ({6'h00, sel} + 11'h001);
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Pending and mask words are only read here, so halting cannot disturb them.
  assign wake = lpcf_wake(interrupt_pending_word, interrupt_mask_word);
  assign access_ok = cocr_sel && (cocr_fc == lpcf_pkg::COCR_FC);
  assign halt_en = {q.scw.halt_watchdog_enable, q.scw.halt_timer_two_enable,
                    q.scw.halt_timer_one_enable};

  // One process computes every field of lpcf_main_state_type; the divider and clock output keep their own registers.
  always_comb begin
    d = q;
    d.scw = system_control_word;
    case (q.lp)
      LPCF_RUN: begin
        if (stop_executed && q.scw.sleep_enable) begin
          d.lp = LPCF_SLEEP;
        end
      end
      LPCF_SLEEP: begin
        if (wake) begin
          if (q.scw.recovery_reset_select) begin
            d.lp = LPCF_CORE_RESET;
            d.hold_cnt = 4'h0;
          end else begin
            d.lp = LPCF_RUN;
          end
        end
      end
      LPCF_CORE_RESET: begin
        if (q.hold_cnt == lpcf_pkg::HOLD_LAST) begin
          d.lp = LPCF_RUN;
        end else begin
          d.hold_cnt = q.hold_cnt + 4'h1;
        end
      end
      default: begin
        d.lp = LPCF_RUN;
      end
    endcase
    d.sleeping = (d.lp == LPCF_SLEEP);
    // Only the core sees the reset; peripheral state stays untouched.
    d.core_reset = (d.lp == LPCF_CORE_RESET);

    // Halt takes effect one clock after the input is seen.
    d.comms_freeze = debug_halt_input;
    d.dma_hold = debug_halt_input;
    // The bus is given up only once a cycle in flight has been acknowledged.
    d.dma_release = debug_halt_input && (!dma_cycle_active || dma_ack);
    for (int i = 0; i < 3; i++) begin
      d.timer_halt[i] = debug_halt_input && halt_en[i];
    end

    // Pin control; a floated pin relies on an external pullup.
    d.tx_o = scc_tx_clock_out;
    d.tx_oe_b = q.cocr.tx_clock_pin_float || !scc_tx_clock_drive;
    d.rx_o = scc_rx_clock_out;
    d.rx_oe_b = q.cocr.rx_clock_pin_float || !scc_rx_clock_drive;
    // Forcing is registered with the pin, so toggling the bit cannot glitch the pin.
    d.baud_o = q.cocr.baud_pin_disable || baud_generator_out;

    // Register access: any other function code is ignored and not acknowledged.
    d.ack = access_ok;
    d.rdata = 16'h0000;
    if (access_ok) begin
      if (cocr_write) begin
        // Reserved bits are not stored, so stray ones never read back.
        d.cocr = lpcf_pkg::lpcf_cocr_type'(cocr_wdata[lpcf_pkg::MODE_MSB:
                                                      lpcf_pkg::BAUD_DIS_BIT]);
      end else begin
        d.rdata = {q.cocr, lpcf_pkg::COCR_RESERVED_ZERO};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset clears the register copy, the sampled control word and all pins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cocr_rdata = q.rdata;
  assign cocr_ack = q.ack;
  assign sleeping = q.sleeping;
  assign core_reset = q.core_reset;
  assign comms_freeze = q.comms_freeze;
  assign dma_hold = q.dma_hold;
  assign dma_bus_release = q.dma_release;
  assign timer_halt = q.timer_halt;
  assign serial_tx_clock_pin = q.tx_o;
  assign serial_tx_clock_pin_oe_b = q.tx_oe_b;
  assign serial_rx_clock_pin = q.rx_o;
  assign serial_rx_clock_pin_oe_b = q.rx_oe_b;
  assign baud_generator_pin = q.baud_o;

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  // The divider runs at full rate unless the next state is sleep, keeping tick aligned.
  lpcf_div u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run_full(d.lp != LPCF_SLEEP),
    .divider_select(q.scw.core_divider_select),
    .prescale_sixteen(q.scw.divider_prescale_sixteen),
    .core_clk_tick(core_clk_tick)
  );

  // Clock output pin and its drive mode.
  lpcf_system_clock_output u_system_clock_output (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mode_request(q.cocr.clock_out_drive_mode),
    .system_clock_output(system_clock_output),
    .system_clock_output_oe_b(system_clock_output_oe_b),
    .clock_out_drive_mode(clock_out_drive_mode)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking lpcf_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Helper: cycles since the last tick and whether the sleep setting stayed put.
  logic [10:0] gap_q;
  logic seen_q;
  logic [5:0] cfg_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 11'h000;
      seen_q <= 1'b0;
      cfg_q <= 6'h00;
    end else begin
      gap_q <= core_clk_tick ? 11'h000 : gap_q + 11'h001;
      seen_q <= sleeping && ({q.scw.divider_prescale_sixteen, q.scw.core_divider_select}
                == cfg_q) && (core_clk_tick || seen_q);
      cfg_q <= {q.scw.divider_prescale_sixteen, q.scw.core_divider_select};
    end
  end

  sequence s_hold_first;
    core_reset[*8];
  endsequence
  sequence s_hold_second;
    core_reset[*8] ##1 !core_reset;
  endsequence

  property p_entry;
    $rose(sleeping) |-> $past(stop_executed) && $past(q.scw.sleep_enable);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entered without enable");
  property p_stay;
    sleeping && !wake |=> sleeping && !core_reset;
  endproperty
  a_stay: assert property (p_stay) else $error("sleep left without wake");
  property p_soft_wake;
    sleeping && wake && !q.scw.recovery_reset_select |=> !sleeping && !core_reset
      && core_clk_tick;
  endproperty
  a_soft_wake: assert property (p_soft_wake) else $error("bad soft wake");
  property p_hard_wake;
    sleeping && wake && q.scw.recovery_reset_select |=> s_hold_first ##1 s_hold_second;
  endproperty
  a_hard_wake: assert property (p_hard_wake) else $error("core reset not 16 cycles");
  property p_ratio;
    sleeping && core_clk_tick && seen_q |->
      gap_q == lpcf_ratio(cfg_q[5], cfg_q[4:0]) - 11'h001;
  endproperty
  a_ratio: assert property (p_ratio) else $error("core tick spacing wrong");
  property p_mode_change;
    $changed(clock_out_drive_mode) |-> $past(system_clock_output);
  endproperty
  a_mode_change: assert property (p_mode_change) else $error("mode changed low");
  property p_system_clock_output_off;
    clock_out_drive_mode == lpcf_pkg::MODE_OFF |-> system_clock_output
      && system_clock_output_oe_b;
  endproperty
  a_system_clock_output_off: assert property (p_system_clock_output_off) else $error("disabled output driven");
  property p_float;
    q.cocr.tx_clock_pin_float && q.cocr.rx_clock_pin_float |=> serial_tx_clock_pin_oe_b
      && serial_rx_clock_pin_oe_b;
  endproperty
  a_float: assert property (p_float) else $error("floated pin still driven");
  property p_baud;
    q.cocr.baud_pin_disable |=> baud_generator_pin;
  endproperty
  a_baud: assert property (p_baud) else $error("baud pin not forced high");
  property p_bad_fc;
    cocr_sel && cocr_write && cocr_fc != lpcf_pkg::COCR_FC |=> $stable(q.cocr) && !cocr_ack;
  endproperty
  a_bad_fc: assert property (p_bad_fc) else $error("wrong space wrote register");
  property p_halt;
    debug_halt_input |=> comms_freeze && dma_hold && timer_halt == $past(halt_en);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not applied");
  property p_dma;
    debug_halt_input && dma_cycle_active && !dma_ack |=> !dma_bus_release;
  endproperty
  a_dma: assert property (p_dma) else $error("bus released mid cycle");
endmodule

// ---- lpcf_partner.sv ----
// Behavioural core and DMA engine that stand on the far side of the control block.
`timescale 1ns/1ns
module lpcf_partner (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic stop_req,
  input wire logic dma_req,
  input wire logic [3:0] ack_wait,
  input wire logic dma_hold,
  output logic stop_executed,
  output logic dma_cycle_active,
  output logic dma_ack
);
  // -------------------------------------------------------------------------
  // Core stop report and one DMA bus cycle per request
  // -------------------------------------------------------------------------
  logic [3:0] wait_q;

  // The acknowledge comes while the cycle is still active, as a slow slave would give it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_executed <= 1'h0;
      dma_cycle_active <= 1'h0;
      dma_ack <= 1'h0;
      wait_q <= 4'h0;
    end else begin
      stop_executed <= stop_req;
      dma_ack <= 1'h0;
      if (!dma_cycle_active) begin
        if (dma_req && !dma_hold) begin
          dma_cycle_active <= 1'h1;
          wait_q <= ack_wait;
        end
      end else if (dma_ack) begin
        dma_cycle_active <= 1'h0;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else begin
        dma_ack <= 1'h1;
      end
    end
  end
endmodule

// ---- low_power_clock_and_freeze_ctrl_bench.sv ----
// Self-checking bench for the low-power clock and freeze control block.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module low_power_clock_and_freeze_ctrl_bench;
  logic core_clk, rst_b, cocr_sel, cocr_write, stop_req, dma_req, debug_halt_input;
  logic scc_tx_clock_out, scc_tx_clock_drive, scc_rx_clock_out, scc_rx_clock_drive;
  logic baud_generator_out, stop_executed, dma_cycle_active, dma_ack;
  logic [2:0] cocr_fc;
  logic [15:0] cocr_wdata, interrupt_pending_word, interrupt_mask_word, cocr_rdata, rd;
  lpcf_pkg::lpcf_scw_type system_control_word;
  logic cocr_ack, core_clk_tick, core_reset, sleeping, comms_freeze, dma_hold, dma_bus_release;
  logic [2:0] timer_halt;
  logic serial_tx_clock_pin, serial_tx_clock_pin_oe_b;
  logic serial_rx_clock_pin, serial_rx_clock_pin_oe_b;
  logic baud_generator_pin, system_clock_output, system_clock_output_oe_b, last_sco, ak;
  logic [1:0] clock_out_drive_mode, last_mode;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  lpcf_ctrl i_dut (.core_clk, .rst_b, .cocr_sel, .cocr_write, .cocr_fc, .cocr_wdata,
    .cocr_rdata, .cocr_ack, .system_control_word, .stop_executed, .interrupt_pending_word,
    .interrupt_mask_word, .debug_halt_input, .dma_cycle_active, .dma_ack, .scc_tx_clock_out,
    .scc_tx_clock_drive, .scc_rx_clock_out, .scc_rx_clock_drive, .baud_generator_out,
    .core_clk_tick, .core_reset, .sleeping, .comms_freeze, .dma_hold, .dma_bus_release,
    .timer_halt, .serial_tx_clock_pin, .serial_tx_clock_pin_oe_b, .serial_rx_clock_pin,
    .serial_rx_clock_pin_oe_b, .baud_generator_pin, .system_clock_output,
    .system_clock_output_oe_b, .clock_out_drive_mode);

  lpcf_partner i_partner (.core_clk, .rst_b, .stop_req, .dma_req, .ack_wait(4'h4),
    .dma_hold, .stop_executed, .dma_cycle_active, .dma_ack);

  // -------------------------------------------------------------------------
  // Clock, hang guard and clock output monitor
  // -------------------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // The whole run needs under a thousand cycles, so this ceiling only trips on a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // A drive mode change must land on an edge where the clock output was high.
  always @(posedge core_clk) begin
    #1;
    if (rst_b === 1'h1 && clock_out_drive_mode !== last_mode) `CHK(last_sco, 1'h1)
    last_mode = clock_out_drive_mode;
    last_sco = system_clock_output;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  // One register access; the answer is looked for in the three cycles after the take.
  task automatic acc(input logic w, input logic [2:0] f, input logic [15:0] d);
    @(posedge core_clk);
    cocr_sel <= 1'h1;
    cocr_write <= w;
    cocr_fc <= f;
    cocr_wdata <= d;
    @(posedge core_clk);
    cocr_sel <= 1'h0;
    ak = 1'h0;
    rd = 16'h0000;
    repeat (3) begin
      #1;
      if (cocr_ack === 1'h1 && ak === 1'h0) begin
        ak = 1'h1;
        rd = cocr_rdata;
      end
      @(posedge core_clk);
    end
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_register;
    acc(1'h0, 3'h5, 16'h0000);
    `CHK(rd, 16'h0000)
    acc(1'h1, 3'h5, 16'hF800);
    `CHK(ak, 1'h1)
    acc(1'h0, 3'h5, 16'h0000);
    `CHK(rd, 16'hF800)
    acc(1'h1, 3'h4, 16'h0000);
    `CHK(ak, 1'h0)
    acc(1'h0, 3'h5, 16'h0000);
    `CHK(rd, 16'hF800)
  endtask

  task automatic t_pins(input logic [15:0] d, input logic fl);
    acc(1'h1, 3'h5, d);
    repeat (3) step();
    `CHK(serial_tx_clock_pin_oe_b, fl)
    `CHK(serial_rx_clock_pin_oe_b, fl)
    `CHK(baud_generator_pin, fl)
    if (!fl) `CHK(serial_tx_clock_pin, 1'h1)
    if (!fl) `CHK(serial_rx_clock_pin, 1'h1)
    // The set bit floats the pin though the channel drives; with the bit clear, stopping the channel floats it.
    @(posedge core_clk);
    scc_rx_clock_drive <= fl;
    repeat (2) step();
    `CHK(serial_rx_clock_pin_oe_b, 1'h1)
  endtask

  task automatic t_clk_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      acc(1'h1, 3'h5, {m, 14'h0000});
      repeat (4) step();
      `CHK(clock_out_drive_mode, m)
      if (m == 2'h3) begin
        `CHK(system_clock_output_oe_b, 1'h1)
        `CHK(system_clock_output, 1'h1)
      end else begin
        `CHK(system_clock_output_oe_b, 1'h0)
      end
    end
  endtask

  task automatic stop_pulse;
    @(posedge core_clk);
    stop_req <= 1'h1;
    @(posedge core_clk);
    stop_req <= 1'h0;
  endtask

  task automatic t_sleep(input logic [4:0] n, input logic ps, input logic rec, input int per);
    int k;
    int cnt;
    @(posedge core_clk);
    system_control_word <= '{core_divider_select: n, sleep_enable: 1'h1,
      divider_prescale_sixteen: ps, recovery_reset_select: rec, default: 1'h0};
    repeat (2) step();
    stop_pulse();
    for (k = 0; k < 6 && sleeping !== 1'h1; k++) step();
    `CHK(sleeping, 1'h1)
    for (k = 0; k < 2000 && core_clk_tick !== 1'h0; k++) step();
    for (k = 0; k < 2000 && core_clk_tick !== 1'h1; k++) step();
    for (k = 1; k < 2000; k++) begin
      step();
      if (core_clk_tick === 1'h1) break;
    end
    `CHK(k, per)
    @(posedge core_clk);
    interrupt_pending_word <= 16'h0800;
    repeat (10) step();
    `CHK(sleeping, 1'h1)
    @(posedge core_clk);
    interrupt_mask_word <= 16'h0800;
    for (k = 0; k < 6 && sleeping !== 1'h0; k++) step();
    `CHK(sleeping, 1'h0)
    `CHK(core_clk_tick, 1'h1)
    cnt = (core_reset === 1'h1) ? 1 : 0;
    repeat (24) begin
      step();
      if (core_reset === 1'h1) cnt++;
    end
    `CHK(cnt, rec ? 16 : 0)
    @(posedge core_clk);
    interrupt_pending_word <= 16'h0000;
    interrupt_mask_word <= 16'h0000;
  endtask

  task automatic t_no_enable;
    @(posedge core_clk);
    system_control_word <= '{core_divider_select: 5'h03, default: 1'h0};
    repeat (2) step();
    stop_pulse();
    repeat (6) step();
    `CHK(sleeping, 1'h0)
  endtask

  task automatic t_halt;
    @(posedge core_clk);
    system_control_word <= '{halt_timer_one_enable: 1'h1, halt_watchdog_enable: 1'h1,
      default: 1'h0};
    dma_req <= 1'h1;
    for (int k = 0; k < 8 && dma_cycle_active !== 1'h1; k++) step();
    @(posedge core_clk);
    debug_halt_input <= 1'h1;
    dma_req <= 1'h0;
    ak = 1'h0;
    repeat (10) begin
      step();
      `CHK(dma_bus_release, ak)
      if (dma_ack === 1'h1) ak = 1'h1;
    end
    `CHK(comms_freeze, 1'h1)
    `CHK(dma_hold, 1'h1)
    `CHK(timer_halt, 3'h5)
    @(posedge core_clk);
    debug_halt_input <= 1'h0;
    step();
    `CHK(comms_freeze, 1'h0)
    `CHK(timer_halt, 3'h0)
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    {cocr_sel, cocr_write, stop_req, dma_req} = 4'h0;
    debug_halt_input = 1'h0;
    {scc_tx_clock_out, scc_tx_clock_drive, scc_rx_clock_out, scc_rx_clock_drive} = 4'hF;
    baud_generator_out = 1'h0;
    cocr_fc = 3'h0;
    cocr_wdata = 16'h0000;
    interrupt_pending_word = 16'h0000;
    interrupt_mask_word = 16'h0000;
    system_control_word = '0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'h1;
    step();
    `CHK(sleeping, 1'h0)
    `CHK(timer_halt, 3'h0)
    t_register();
    t_pins(16'h3800, 1'h1);
    t_pins(16'h0000, 1'h0);
    t_clk_modes();
    t_no_enable();
    t_sleep(5'h03, 1'h0, 1'h0, 8);
    t_sleep(5'h1F, 1'h0, 1'h0, 64);
    t_sleep(5'h01, 1'h1, 1'h0, 64);
    t_sleep(5'h00, 1'h1, 1'h1, 32);
    t_halt();
    conclude();
  end
endmodule
